// file: hw/uip_pkg.sv
// Package for the UART interrupt prioritizer: codes, fields and types
package uip_pkg;
  // Enable mask fields
  localparam int IEN_RX_RDY    = 0;
  localparam int IEN_TX_RDY    = 1;
  localparam int IEN_LINE      = 2;
  localparam int IEN_MODEM     = 3;
  localparam int IEN_STOP_CHAR = 5;
  localparam int EXT_EN_LO     = 4;
  localparam logic [7:0] IEN_RESET = 8'h00;
  localparam logic [7:0] IEN_BASE_MASK = 8'h0f;
  // Line status bits that raise the line interrupt
  localparam int LSR_OVERRUN = 1;
  localparam logic [3:0] LSR_ERR_MASK = 4'he;
  // Modem status bits 0..3
  localparam logic [3:0] MSR_CHG_MASK = 4'hf;
  // Source codes, bits 5..0
  localparam logic [5:0] SRC_LINE    = 6'h06;
  localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
  localparam logic [5:0] SRC_RX_RDY  = 6'h04;
  localparam logic [5:0] SRC_TX_RDY  = 6'h02;
  localparam logic [5:0] SRC_MODEM   = 6'h00;
  localparam logic [5:0] SRC_STOP    = 6'h10;
  localparam logic [5:0] SRC_NONE    = 6'h01;
  localparam logic [1:0] FIFO_ON_BITS  = 2'h3;
  localparam logic [1:0] FIFO_OFF_BITS = 2'h0;

  // Host register access strobes, one cycle each
  typedef struct packed {
    logic       ien_wr;
    logic [7:0] ien_wdata;
    logic       src_rd;
    logic       lsr_rd;
    logic       msr_rd;
    logic       rhr_rd;
    logic       thr_wr;
  } uip_host_t;

  // Status and events from the receive/transmit datapath
  typedef struct packed {
    logic       fifo_en;
    logic       rx_data_ready;
    logic       rx_at_trigger;
    logic       tx_empty;
    logic       tx_below_trigger;
    logic       overrun_now;
    logic [2:0] err_arrive;
    logic [2:0] err_readout;
    logic       timeout_expired;
    logic [3:0] msr_bits;
    logic       stop_char_match;
    logic       resume_char_rx;
    logic       special_match;
    logic       char_received;
    logic       sleep_exit;
  } uip_dp_t;
endpackage

// file: hw/uip_prio.sv
// Interrupt enable, source encoding, priority and clearing for one UART channel
module uip_prio
  import uip_pkg::*;
(
  input  wire logic      SYS_CLK,
  input  wire logic      RESET,
  input  wire uip_host_t HOST,
  input  wire uip_dp_t   DP,
  input  wire logic      FEATURE_EN,
  input  wire logic      ERR_IMMEDIATE,
  output logic [7:0]     IEN_RDATA,
  output logic [7:0]     SRC_RDATA,
  output logic           IRQ
);

  logic [7:0] ien_q;
  logic       line_q;
  logic       timeout_q;
  logic       tx_q;
  logic       tx_empty_q;
  logic       modem_q;
  logic       stop_q;
  logic       special_q;
  logic       wake_q;
  logic       rx_lvl;
  logic       src_rd_q;
  logic [7:0] src_d;
  logic [7:0] src_q;
  logic       irq_d;

  // Enable mask register
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ien_q <= IEN_RESET;
    end else if (HOST.ien_wr) begin
      ien_q[3:0] <= HOST.ien_wdata[3:0];
      if (FEATURE_EN) begin
        ien_q[7:4] <= HOST.ien_wdata[7:4];
      end
    end
  end

  // Line status: overrun at arrival, other errors at arrival or readout
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      line_q <= 1'b0;
    end else if (DP.overrun_now || (ERR_IMMEDIATE ? |DP.err_arrive : |DP.err_readout)) begin
      line_q <= 1'b1;
    end else if (HOST.lsr_rd) begin
      line_q <= 1'b0;
    end
  end

  // Receive timeout
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      timeout_q <= 1'b0;
    end else if (DP.timeout_expired) begin
      timeout_q <= 1'b1;
    end else if (HOST.rhr_rd) begin
      timeout_q <= 1'b0;
    end
  end

  // Receive ready follows level; clears when level drops
  assign rx_lvl = DP.fifo_en ? DP.rx_at_trigger : DP.rx_data_ready;

  // Transmit ready: event on entry to empty (below trigger with FIFO on), or on enabling while in that state
  logic tx_cond;
  logic tx_set;
  assign tx_cond = DP.fifo_en ? DP.tx_below_trigger : DP.tx_empty;
  assign tx_set  = (tx_cond && !tx_empty_q) ||
                   (HOST.ien_wr && HOST.ien_wdata[IEN_TX_RDY] && !ien_q[IEN_TX_RDY] && tx_cond);
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      tx_empty_q <= 1'b0;
    end else begin
      tx_empty_q <= tx_cond;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      tx_q <= 1'b0;
    end else if (tx_set) begin
      tx_q <= 1'b1;
    end else if ((src_rd_q && src_q[5:0] == SRC_TX_RDY) || HOST.thr_wr) begin
      tx_q <= 1'b0;
    end
  end

  // Modem status
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      modem_q <= 1'b0;
    end else if (|(DP.msr_bits & MSR_CHG_MASK)) begin
      modem_q <= 1'b1;
    end else if (HOST.msr_rd) begin
      modem_q <= 1'b0;
    end
  end

  // Stop character and special character
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      stop_q <= 1'b0;
    end else if (DP.stop_char_match) begin
      stop_q <= 1'b1;
    end else if ((src_rd_q && src_q[5:0] == SRC_STOP) || DP.resume_char_rx) begin
      stop_q <= 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      special_q <= 1'b0;
    end else if (DP.special_match) begin
      special_q <= 1'b1;
    end else if ((src_rd_q && src_q[5:0] == SRC_STOP) || DP.char_received) begin
      special_q <= 1'b0;
    end
  end

  // Wake-up indication
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      wake_q <= 1'b0;
    end else if (DP.sleep_exit) begin
      wake_q <= 1'b1;
    end else if (src_rd_q) begin
      wake_q <= 1'b0;
    end
  end

  // Clears act on the value latched at the end of the read cycle
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      src_rd_q <= 1'b0;
    end else begin
      src_rd_q <= HOST.src_rd;
    end
  end

  // Priority encoder; wake-up source never reported
  logic e_line;
  logic e_to;
  logic e_rx;
  logic e_tx;
  logic e_md;
  logic e_st;
  assign e_line = ien_q[IEN_LINE] && line_q;
  assign e_to   = ien_q[IEN_RX_RDY] && timeout_q;
  assign e_rx   = ien_q[IEN_RX_RDY] && rx_lvl;
  assign e_tx   = ien_q[IEN_TX_RDY] && tx_q;
  assign e_md   = ien_q[IEN_MODEM] && modem_q;
  assign e_st   = ien_q[IEN_STOP_CHAR] && (stop_q || special_q);

  always_comb begin
    src_d[7:6] = DP.fifo_en ? FIFO_ON_BITS : FIFO_OFF_BITS;
    if (e_line)    src_d[5:0] = SRC_LINE;
    else if (e_to) src_d[5:0] = SRC_TIMEOUT;
    else if (e_rx) src_d[5:0] = SRC_RX_RDY;
    else if (e_tx) src_d[5:0] = SRC_TX_RDY;
    else if (e_md) src_d[5:0] = SRC_MODEM;
    else if (e_st) src_d[5:0] = SRC_STOP;
    else           src_d[5:0] = SRC_NONE;
    irq_d = e_line | e_to | e_rx | e_tx | e_md | e_st;
  end

  // Snapshot held from the second cycle of a read so presented value stays put
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      src_q <= {FIFO_OFF_BITS, SRC_NONE};
      IRQ   <= 1'b0;
    end else begin
      if (!HOST.src_rd || !src_rd_q) begin
        src_q <= src_d;
      end
      IRQ <= irq_d;
    end
  end

  assign SRC_RDATA = src_q;
  assign IEN_RDATA = ien_q;

  // Checks
  property p_upper_locked;
    @(posedge SYS_CLK) disable iff (RESET)
      (HOST.ien_wr && !FEATURE_EN) |=> ien_q[7:4] == $past(ien_q[7:4]);
  endproperty
  a_upper_locked: assert property (p_upper_locked) else $error("upper enables changed");

  property p_bit5_zero;
    @(posedge SYS_CLK) disable iff (RESET) SRC_RDATA[5] == 1'b0;
  endproperty
  a_bit5_zero: assert property (p_bit5_zero) else $error("bit 5 set");

  property p_idle_code;
    @(posedge SYS_CLK) disable iff (RESET) (!IRQ && !$past(HOST.src_rd)) |-> SRC_RDATA[0];
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("bit 0 low when idle");

  property p_irq_follows;
    @(posedge SYS_CLK) disable iff (RESET)
      (e_line && ien_q == $past(ien_q)) |=> IRQ;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

  property p_line_prio;
    @(posedge SYS_CLK) disable iff (RESET)
      (e_line && !HOST.src_rd) |=> SRC_RDATA[5:0] == SRC_LINE;
  endproperty
  a_line_prio: assert property (p_line_prio) else $error("line not top");

  property p_lsr_clear;
    @(posedge SYS_CLK) disable iff (RESET)
      (HOST.lsr_rd && !DP.overrun_now && !(|DP.err_arrive) && !(|DP.err_readout))
        |=> !line_q;
  endproperty
  a_lsr_clear: assert property (p_lsr_clear) else $error("line not cleared");

  property p_thr_clear;
    @(posedge SYS_CLK) disable iff (RESET) (HOST.thr_wr && !tx_set) |=> !tx_q;
  endproperty
  a_thr_clear: assert property (p_thr_clear) else $error("tx not cleared");

  property p_fifo_bits;
    @(posedge SYS_CLK) disable iff (RESET)
      (DP.fifo_en && !HOST.src_rd) ##1 DP.fifo_en |=> SRC_RDATA[7:6] == FIFO_ON_BITS;
  endproperty
  a_fifo_bits: assert property (p_fifo_bits) else $error("fifo bits wrong");

  property p_wake_set;
    @(posedge SYS_CLK) disable iff (RESET)
      DP.sleep_exit |=> wake_q;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake not set");

  property p_wake_clear;
    @(posedge SYS_CLK) disable iff (RESET)
      (src_rd_q && !DP.sleep_exit) |=> !wake_q;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake not cleared");

  property p_timeout_clear;
    @(posedge SYS_CLK) disable iff (RESET)
      (HOST.rhr_rd && !DP.timeout_expired) |=> !timeout_q;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear) else $error("timeout kept");

  property p_modem_set;
    @(posedge SYS_CLK) disable iff (RESET)
      (|(DP.msr_bits & MSR_CHG_MASK)) |=> modem_q;
  endproperty
  a_modem_set: assert property (p_modem_set) else $error("modem not set");

  property p_msr_clear;
    @(posedge SYS_CLK) disable iff (RESET)
      (HOST.msr_rd && !(|(DP.msr_bits & MSR_CHG_MASK))) |=> !modem_q;
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("modem not cleared");

  property p_stop_set;
    @(posedge SYS_CLK) disable iff (RESET)
      (DP.stop_char_match || DP.special_match) |=> (stop_q || special_q);
  endproperty
  a_stop_set: assert property (p_stop_set) else $error("stop not set");

  property p_resume_clear;
    @(posedge SYS_CLK) disable iff (RESET)
      (DP.resume_char_rx && !DP.stop_char_match) |=> !stop_q;
  endproperty
  a_resume_clear: assert property (p_resume_clear) else $error("stop kept");

  property p_next_char_clear;
    @(posedge SYS_CLK) disable iff (RESET)
      (DP.char_received && !DP.special_match) |=> !special_q;
  endproperty
  a_next_char_clear: assert property (p_next_char_clear) else $error("special kept");

  property p_tx_enable_set;
    @(posedge SYS_CLK) disable iff (RESET)
      (HOST.ien_wr && HOST.ien_wdata[IEN_TX_RDY] && !ien_q[IEN_TX_RDY] && tx_cond) |=> tx_q;
  endproperty
  a_tx_enable_set: assert property (p_tx_enable_set) else $error("tx not raised");

  property p_irq_clear;
    @(posedge SYS_CLK) disable iff (RESET)
      !(e_line || e_to || e_rx || e_tx || e_md || e_st) |=> !IRQ;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq stuck");

endmodule // uip_prio

// file: verification/uip_host_model.sv
// Host processor model driving register access strobes
module uip_host_model
  import uip_pkg::*;
(
  input  wire logic clk,
  output uip_host_t host
);
  timeunit 1ns;
  timeprecision 1ns;

  initial host = '0;

  task automatic wr_ien(input logic [7:0] v);
    host.ien_wr    = 1'b1;
    host.ien_wdata = v;
    @(negedge clk);
    host = '0;
    // Idle edge keeps back-to-back strobes apart
    @(negedge clk);
  endtask

  // 0 source, 1 line, 2 modem, 3 receive read; 4 transmit write
  task automatic acc(input int sel);
    host.src_rd = (sel == 0);
    host.lsr_rd = (sel == 1);
    host.msr_rd = (sel == 2);
    host.rhr_rd = (sel == 3);
    host.thr_wr = (sel == 4);
    @(negedge clk);
    host = '0;
    @(negedge clk);
  endtask
endmodule // uip_host_model

// file: verification/uip_prio_bench.sv
// Self-checking bench for the interrupt prioritizer
module uip_prio_bench
  import uip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       sys_clk = 1'b0;
  logic       reset   = 1'b1;
  logic       feat_en = 1'b0;
  logic       err_imm = 1'b0;
  uip_dp_t    dp      = '0;
  uip_dp_t    p;
  uip_host_t  hbus;
  logic [7:0] ien_rd;
  logic [7:0] src_rd;
  logic       irq;
  logic [2:0] e;
  logic       imm;
  logic [7:0] wv;
  logic [7:0] prev_ien;
  int         miscompares = 0;
  int         cmp_count   = 0;

  always #10 sys_clk = ~sys_clk;

  uip_host_model host (.clk(sys_clk), .host(hbus));
  uip_prio dut (.SYS_CLK(sys_clk), .RESET(reset), .HOST(hbus), .DP(dp),
    .FEATURE_EN(feat_en), .ERR_IMMEDIATE(err_imm), .IEN_RDATA(ien_rd),
    .SRC_RDATA(src_rd), .IRQ(irq));

  function automatic logic [7:0] exp_src(input logic [5:0] code);
    return {dp.fifo_en ? FIFO_ON_BITS : FIFO_OFF_BITS, code};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Let a flag reach the outputs, then compare code and interrupt line
  task automatic look(input logic [5:0] code);
    repeat (3) @(negedge sys_clk);
    chk(src_rd, exp_src(code));
    chk({7'h00, irq}, {7'h00, code != SRC_NONE});
  endtask

  task automatic fire(input uip_dp_t q);
    dp = uip_dp_t'(dp | q);
    @(negedge sys_clk);
    dp = uip_dp_t'(dp & ~q);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #500us;
    miscompares++;
    test_done;
  end

  initial begin
    void'($urandom(32'hebb5af42));
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    chk(ien_rd, IEN_RESET);
    look(SRC_NONE);
    host.wr_ien(8'hff);
    chk(ien_rd, IEN_BASE_MASK);
    host.wr_ien(8'h00);
    p = '0;
    p.overrun_now = 1'b1;
    fire(p);
    look(SRC_NONE);
    host.acc(1);
    feat_en = 1'b1;
    host.wr_ien(8'h2d);
    chk(ien_rd, 8'h2d);
    // All sources but transmit at once, then serviced in priority order
    dp.fifo_en = 1'b1;
    dp.rx_at_trigger = 1'b1;
    dp.msr_bits = 4'($urandom_range(15, 1));
    p.timeout_expired = 1'b1;
    p.stop_char_match = 1'b1;
    fire(p);
    look(SRC_LINE);
    host.acc(1);
    look(SRC_TIMEOUT);
    host.acc(3);
    look(SRC_RX_RDY);
    dp.rx_at_trigger = 1'b0;
    look(SRC_MODEM);
    dp.msr_bits = 4'h0;
    host.acc(2);
    look(SRC_STOP);
    host.acc(0);
    look(SRC_NONE);
    dp.fifo_en = 1'b0;
    dp.tx_empty = 1'b1;
    @(negedge sys_clk);
    // Drop the edge-set flag so only the enable write can raise it
    host.acc(4);
    host.wr_ien(8'h2f);
    look(SRC_TX_RDY);
    host.acc(4);
    look(SRC_NONE);
    dp.tx_empty = 1'b0;
    @(negedge sys_clk);
    dp.tx_empty = 1'b1;
    look(SRC_TX_RDY);
    host.acc(0);
    look(SRC_NONE);
    dp.fifo_en = 1'b1;
    @(negedge sys_clk);
    dp.tx_below_trigger = 1'b1;
    look(SRC_TX_RDY);
    host.acc(0);
    look(SRC_NONE);
    dp.fifo_en = 1'b0;
    dp.tx_below_trigger = 1'b0;
    dp.rx_data_ready = 1'b1;
    look(SRC_RX_RDY);
    dp.rx_data_ready = 1'b0;
    p = '0;
    p.special_match = 1'b1;
    fire(p);
    look(SRC_STOP);
    p = '0;
    p.char_received = 1'b1;
    fire(p);
    look(SRC_NONE);
    p = '0;
    p.stop_char_match = 1'b1;
    fire(p);
    look(SRC_STOP);
    dp.resume_char_rx = 1'b1;
    @(negedge sys_clk);
    dp.resume_char_rx = 1'b0;
    look(SRC_NONE);
    dp.sleep_exit = 1'b1;
    @(negedge sys_clk);
    dp.sleep_exit = 1'b0;
    look(SRC_NONE);
    host.acc(0);
    look(SRC_NONE);
    // Random error flags, arrival versus readout timing
    host.wr_ien(8'h04);
    for (int i = 0; i < 8; i++) begin
      e = 3'($urandom_range(7, 1));
      imm = 1'($urandom_range(1, 0));
      err_imm = imm;
      p = '0;
      p.err_arrive = e;
      fire(p);
      look(imm ? SRC_LINE : SRC_NONE);
      host.acc(1);
      err_imm = 1'b0;
      p = '0;
      p.err_readout = e;
      fire(p);
      look(SRC_LINE);
      host.acc(1);
      look(SRC_NONE);
    end
    // Random enable writes, upper half gated by the feature bit
    for (int i = 0; i < 8; i++) begin
      prev_ien = ien_rd;
      wv = 8'($urandom());
      feat_en = 1'($urandom_range(1, 0));
      host.wr_ien(wv);
      chk(ien_rd, feat_en ? wv : {prev_ien[7:4], wv[3:0]});
    end
    // Reset in mid-run
    dp = '0;
    feat_en = 1'b0;
    reset = 1'b1;
    @(negedge sys_clk);
    chk(ien_rd, IEN_RESET);
    chk(src_rd, {FIFO_OFF_BITS, SRC_NONE});
    chk({7'h00, irq}, 8'h00);
    @(negedge sys_clk);
    reset = 1'b0;
    look(SRC_NONE);
    test_done;
  end
endmodule // uip_prio_bench
